// ### core/acmp_regs.vh
// Register map, field positions and reset values of the converter threshold block
`ifndef ACMP_REGS_VH
`define ACMP_REGS_VH

// Register indices; byte address is four times the index
`define ACMP_IDX_FLAGS        16'h4011
`define ACMP_IDX_MASKS        16'h4019
`define ACMP_IDX_CTRL         16'h4030
`define ACMP_IDX_THR1         16'h4031
`define ACMP_IDX_THR2         16'h4032
`define ACMP_IDX_THR3         16'h4033
`define ACMP_IDX_THR4         16'h4034

// Threshold setup fields
`define ACMP_SRC_HI           15
`define ACMP_SRC_LO           13
`define ACMP_POL_BIT          12
`define ACMP_THR_HI           11
`define ACMP_THR_LO           0
`define ACMP_SETUP_RESET      16'h0000

// Flag and mask fields
`define ACMP_DRDY_BIT         8
`define ACMP_TRIP_HI          7
`define ACMP_TRIP_LO          4
`define ACMP_MASK_RESET       5'h1F

// Control register fields
`define ACMP_STS_HI           11
`define ACMP_STS_LO           8
`define ACMP_ENA_HI           3
`define ACMP_ENA_LO           0
`define ACMP_ENA_RESET        4'h0

// Source codes
`define ACMP_SRC_BACKUP       3'h0
`define ACMP_SRC_PIN10        3'h1
`define ACMP_SRC_PIN11        3'h2
`define ACMP_SRC_PIN12        3'h3
`define ACMP_SRC_TEMP         3'h5
`define ACMP_SRC_SUPPLY       3'h7

`endif

// ### core/acmp_flag.v
// Sticky event flag, cleared by writing one; a set in the clear cycle wins
`timescale 1ns/10ps
module acmp_flag (
  // Clock and reset
  input  wire hclk,
  input  wire hresetn,
  // Event and clear
  input  wire set_i,
  input  wire clr_i,
  // Flag
  output reg  flag_r
);

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flag_r <= 1'b0;
    end else begin
      flag_r <= set_i | (flag_r & ~clr_i);
    end
  end

endmodule // acmp_flag

// ### core/acmp_cmp.v
// One digital threshold comparator with its result status bit
`timescale 1ns/10ps
`include "acmp_regs.vh"
module acmp_cmp #(
  parameter BACKUP_OK = 0
) (
  // Clock and reset
  input  wire        hclk,
  input  wire        hresetn,
  // Setup
  input  wire        enable_i,
  input  wire [15:0] setup_i,
  // Conversion result
  input  wire        conv_done_i,
  input  wire [2:0]  conv_src_i,
  input  wire [11:0] conv_data_i,
  // Outcome
  output wire        trip_evt_o,
  output reg         status_r
);

  wire [2:0]  src_sel;
  wire        pol;
  wire [11:0] thr;
  reg         src_legal;
  wire        eval;
  wire        trip;

  assign src_sel = setup_i[`ACMP_SRC_HI:`ACMP_SRC_LO];
  assign pol     = setup_i[`ACMP_POL_BIT];
  assign thr     = setup_i[`ACMP_THR_HI:`ACMP_THR_LO];

  // Reserved codes never match any conversion
  always @* begin
    case (src_sel)
      `ACMP_SRC_PIN10, `ACMP_SRC_PIN11, `ACMP_SRC_PIN12,
      `ACMP_SRC_TEMP, `ACMP_SRC_SUPPLY : src_legal = 1'b1;
      `ACMP_SRC_BACKUP : src_legal = (BACKUP_OK != 0);
      default          : src_legal = 1'b0;
    endcase
  end

  // Only right after a conversion, only when enabled and on its channel
  assign eval = conv_done_i & enable_i & src_legal & (src_sel == conv_src_i);
  assign trip = pol ? (conv_data_i >= thr) : (conv_data_i < thr);
  assign trip_evt_o = eval & trip;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_r <= 1'b0;
    end else if (eval) begin
      status_r <= trip;
    end
  end

endmodule // acmp_cmp

// ### core/acmp_top.v
// Auxiliary converter threshold comparators and interrupt logic behind an AHB-Lite slave
// Behaviour
// - Comparators one to three take a 3-bit source in bits 15:13; 1,2,3 pins ten to twelve, 5 temperature, 7 supply.
// - Comparator four shares the encoding but code 0 selects the backup battery, which only it can watch.
// - Bit 12 picks trip polarity: 0 trips below the threshold, 1 trips at or above it.
// - The threshold is a 12-bit unsigned field in bits 11:0, reset zero, compared directly with the result.
// - A new result raises the data-ready flag and a crossed threshold raises its comparator flag.
// - Any unmasked flag drives the single primary converter interrupt.
// - Mask bits at 8 and 7:4 block their flags when one, and reset to one.
// - The data-ready flag is bit 8 of the flag register and sets on the rising edge of data-ready.
// - Reading a result never clears data-ready; only writing one to its bit does.
// - Comparator flags one to four sit in bits 7:4, set by their trip and cleared by writing one.
// - Comparisons are made only right after a conversion completes.
// - A comparator acts only while its enable bit is set; disabled ones change nothing.
// - Each comparator shows a status bit holding its latest comparison outcome.
`timescale 1ns/10ps
`include "acmp_regs.vh"
module acmp_top (
  // Clock and reset
  input  wire        hclk,
  input  wire        hresetn,
  // AHB-Lite slave
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire        hreadyout,
  output wire        hresp,
  output reg  [31:0] hrdata,
  // Converter result path
  input  wire        conv_ready,
  input  wire [2:0]  conv_src,
  input  wire [11:0] conv_data,
  // Interrupt
  output wire        converter_primary_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Bus front end

  reg         wr_pend_r;
  reg         rd_pend_r;
  reg  [15:0] idx_r;
  wire        take;
  wire        in_range;

  // Window check keeps aliases of the 16-bit index from decoding
  assign in_range = (haddr[31:18] == 14'h0000) & (haddr[1:0] == 2'h0);
  assign take     = hsel & hready & htrans[1];

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      idx_r     <= 16'h0000;
    end else begin
      wr_pend_r <= take & hwrite & in_range;
      rd_pend_r <= take & ~hwrite;
      if (take) begin
        idx_r <= in_range ? haddr[17:2] : 16'hFFFF;
      end
    end
  end

  // One wait state on reads so a write just before is seen
  assign hreadyout = ~rd_pend_r;
  assign hresp     = 1'b0;

  wire wr_flags = wr_pend_r & (idx_r == `ACMP_IDX_FLAGS);
  wire wr_masks = wr_pend_r & (idx_r == `ACMP_IDX_MASKS);
  wire wr_ctrl  = wr_pend_r & (idx_r == `ACMP_IDX_CTRL);

  ////////////////////////////////////////////////////////////////////////////
  // Software registers

  reg  [15:0] setup_r [0:3];
  reg  [4:0]  mask_r;
  reg  [3:0]  ena_r;
  wire [63:0] setup_flat;

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_setup
      wire wr_this = wr_pend_r & (idx_r == (`ACMP_IDX_THR1 + g));
      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          setup_r[g] <= `ACMP_SETUP_RESET;
        end else if (wr_this) begin
          setup_r[g] <= hwdata[15:0];
        end
      end
      assign setup_flat[g*16 +: 16] = setup_r[g];
    end
  endgenerate

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mask_r <= `ACMP_MASK_RESET;
      ena_r  <= `ACMP_ENA_RESET;
    end else begin
      if (wr_masks) begin
        mask_r <= hwdata[`ACMP_DRDY_BIT:`ACMP_TRIP_LO];
      end
      if (wr_ctrl) begin
        ena_r <= hwdata[`ACMP_ENA_HI:`ACMP_ENA_LO];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data-ready edge and comparators

  reg        conv_ready_d_r;
  wire       conv_done;
  wire [3:0] trip_evt;
  wire [3:0] status;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      conv_ready_d_r <= 1'b0;
    end else begin
      conv_ready_d_r <= conv_ready;
    end
  end

  // A held ready level counts once
  assign conv_done = conv_ready & ~conv_ready_d_r;

  generate
    for (g = 0; g < 4; g = g + 1) begin : g_cmp
      acmp_cmp #(
        .BACKUP_OK (g == 3)
      ) u_cmp (
        .hclk        (hclk),
        .hresetn     (hresetn),
        .enable_i    (ena_r[g]),
        .setup_i     (setup_flat[g*16 +: 16]),
        .conv_done_i (conv_done),
        .conv_src_i  (conv_src),
        .conv_data_i (conv_data),
        .trip_evt_o  (trip_evt[g]),
        .status_r    (status[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Flags and interrupt

  wire [4:0] flag_set;
  wire [4:0] flag;

  // Bit 4 is data-ready, bits 3:0 comparators one to four
  assign flag_set = {conv_done, trip_evt};

  generate
    for (g = 0; g < 5; g = g + 1) begin : g_flag
      acmp_flag u_flag (
        .hclk    (hclk),
        .hresetn (hresetn),
        .set_i   (flag_set[g]),
        .clr_i   (wr_flags & hwdata[`ACMP_TRIP_LO + g]),
        .flag_r  (flag[g])
      );
    end
  endgenerate

  assign converter_primary_irq = |(flag & ~mask_r);

  ////////////////////////////////////////////////////////////////////////////
  // Read data

  reg [15:0] rd_val;

  always @* begin
    rd_val = 16'h0000;
    case (idx_r)
      `ACMP_IDX_FLAGS : rd_val[`ACMP_DRDY_BIT:`ACMP_TRIP_LO] = flag;
      `ACMP_IDX_MASKS : rd_val[`ACMP_DRDY_BIT:`ACMP_TRIP_LO] = mask_r;
      `ACMP_IDX_CTRL  : rd_val = {4'h0, status, 4'h0, ena_r};
      `ACMP_IDX_THR1  : rd_val = setup_r[0];
      `ACMP_IDX_THR2  : rd_val = setup_r[1];
      `ACMP_IDX_THR3  : rd_val = setup_r[2];
      `ACMP_IDX_THR4  : rd_val = setup_r[3];
      default         : rd_val = 16'h0000;
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (rd_pend_r) begin
      hrdata <= {16'h0000, rd_val};
    end
  end

endmodule // acmp_top

// ### bench/acmp_props.sv
// Port-level checks of the threshold block's bus and interrupt behaviour
`timescale 1ns/10ps
module acmp_props (
  // Clock, reset and bus
  input logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp,
  input logic [31:0] haddr, hwdata, hrdata,
  input logic [1:0]  htrans,
  input logic [2:0]  hsize,
  // Converter and interrupt
  input logic        conv_ready, converter_primary_irq,
  input logic [2:0]  conv_src,
  input logic [11:0] conv_data
);
  logic cr_q, wph_r, mwr_r;
  wire  acc   = hsel && hready && htrans[1];
  wire  crise = conv_ready && !cr_q;
  // Mask writes are the only way out of the all-masked reset state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cr_q  <= 1'b0;
      wph_r <= 1'b0;
      mwr_r <= 1'b0;
    end else begin
      cr_q  <= conv_ready;
      wph_r <= acc && hwrite;
      if (acc && hwrite && haddr == 32'h00010064) mwr_r <= 1'b1;
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  ////////////////////////////////////////////////////////////
  property p_resp; hresp == 1'b0; endproperty
  a_resp: assert property (p_resp) else $error("error response");
  property p_rdwait; acc && !hwrite |=> !hreadyout ##1 hreadyout; endproperty
  a_rdwait: assert property (p_rdwait) else $error("read wait wrong");
  property p_wr; acc && hwrite |=> hreadyout; endproperty
  a_wr: assert property (p_wr) else $error("write stalled");
  property p_idle; !acc |=> hreadyout; endproperty
  a_idle: assert property (p_idle) else $error("stall without read");
  property p_hi; hrdata[31:16] == 16'h0000; endproperty
  a_hi: assert property (p_hi) else $error("upper read bits set");
  property p_hold; !$past(crise) && !$past(wph_r) |-> $stable(converter_primary_irq); endproperty
  a_hold: assert property (p_hold) else $error("irq moved alone");
  property p_mask; !mwr_r |-> !converter_primary_irq; endproperty
  a_mask: assert property (p_mask) else $error("irq while masked");
  property p_rise; $rose(converter_primary_irq) |-> $past(crise) || $past(wph_r); endproperty
  a_rise: assert property (p_rise) else $error("irq rose late");
endmodule // acmp_props
bind acmp_top acmp_props chk_u (.*);

// ### bench/acmp_conv_model.sv
// Converter result path model feeding one result per call
`timescale 1ns/10ps
module acmp_conv_model (
  input  logic        hclk,
  output logic        conv_ready,
  output logic [2:0]  conv_src,
  output logic [11:0] conv_data
);
  initial begin
    conv_ready = 1'b0;
    conv_src   = 3'h0;
    conv_data  = 12'h000;
  end
  // Released lines invert so stale values never look valid
  task send(input logic [2:0] s, input logic [11:0] d);
    @(posedge hclk);
    conv_ready <= 1'b1;
    conv_src   <= s;
    conv_data  <= d;
    @(posedge hclk);
    conv_ready <= 1'b0;
    conv_src   <= ~s;
    conv_data  <= ~d;
    @(posedge hclk);
  endtask
endmodule // acmp_conv_model

// ### bench/tb_aux_adc_threshold_compare_irq.sv
// Self-checking bench of the threshold comparators and interrupt flags
`timescale 1ns/10ps
`include "acmp_regs.vh"
module tb_aux_adc_threshold_compare_irq;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hrdata, d;
  logic        hreadyout, hresp, conv_ready, converter_primary_irq;
  logic [2:0]  conv_src;
  logic [11:0] conv_data;
  wire         hready = hreadyout;
  integer      fails = 0, checks_done = 0, c;
  always #4 hclk = ~hclk;
  acmp_top dut_u (.*);
  acmp_conv_model conv_u (.*);
  ////////////////////////////////////////////////////////////
  task conclude;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    checks_done = checks_done + 1;
    if (s !== e) begin
      fails = fails + 1;
      $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // Judge readiness at the falling edge, act at the next rising one
  task w;
    integer n;
    n = 0;
    @(negedge hclk);
    while (hreadyout !== 1'b1 && n < 50) begin
      n = n + 1;
      @(negedge hclk);
    end
    if (n >= 50) begin
      fails = fails + 1;
      conclude;
    end
    @(posedge hclk);
  endtask
  task xfer(input logic [15:0] i, input logic wr, input logic [31:0] v);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr  <= {14'h0, i, 2'h0};
    w;
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= v;
    w;
    d = hrdata;
  endtask
  task wr(input logic [15:0] i, input logic [31:0] v);
    xfer(i, 1'b1, v);
  endtask
  task rc(input logic [15:0] i, input logic [31:0] e);
    xfer(i, 1'b0, 32'h0);
    chk(d, e);
  endtask
  task irq(input logic e);
    @(negedge hclk);
    chk({31'h0, converter_primary_irq}, {31'h0, e});
  endtask
  ////////////////////////////////////////////////////////////
  task s_reset;
    rc(`ACMP_IDX_MASKS, 32'h1F0);
    rc(`ACMP_IDX_FLAGS, 32'h0);
    for (c = 0; c < 5; c = c + 1) rc(`ACMP_IDX_CTRL + c[15:0], 32'h0);
    wr(16'h4020, 32'hFFFF);
    rc(16'h4020, 32'h0);
  endtask
  task s_codes;
    wr(`ACMP_IDX_CTRL, 32'h1);
    for (c = 0; c < 8; c = c + 1) begin
      wr(`ACMP_IDX_THR1, {16'h0, c[2:0], 13'h1000});
      conv_u.send(c[2:0], 12'h123);
      rc(`ACMP_IDX_FLAGS, (c == 0 || c == 4 || c == 6) ? 32'h100 : 32'h110);
      wr(`ACMP_IDX_FLAGS, 32'h1F0);
    end
  endtask
  task s_pol;
    wr(`ACMP_IDX_THR1, 32'h3800);
    wr(`ACMP_IDX_THR2, 32'h2800);
    wr(`ACMP_IDX_THR3, 32'h2801);
    wr(`ACMP_IDX_CTRL, 32'h7);
    conv_u.send(3'h1, 12'h800);
    rc(`ACMP_IDX_FLAGS, 32'h150);
    rc(`ACMP_IDX_CTRL, 32'h507);
    conv_u.send(3'h1, 12'h7FF);
    rc(`ACMP_IDX_FLAGS, 32'h170);
    rc(`ACMP_IDX_CTRL, 32'h607);
  endtask
  task s_bat;
    wr(`ACMP_IDX_FLAGS, 32'h1F0);
    wr(`ACMP_IDX_THR4, 32'h1100);
    wr(`ACMP_IDX_THR1, 32'h1000);
    wr(`ACMP_IDX_CTRL, 32'h9);
    conv_u.send(3'h0, 12'h100);
    conv_u.send(3'h1, 12'h000);
    rc(`ACMP_IDX_FLAGS, 32'h180);
    rc(`ACMP_IDX_CTRL, 32'hE09);
  endtask
  task s_irq;
    irq(1'b0);
    wr(`ACMP_IDX_MASKS, 32'h170);
    irq(1'b1);
    rc(`ACMP_IDX_FLAGS, 32'h180);
    wr(`ACMP_IDX_FLAGS, 32'h0);
    rc(`ACMP_IDX_FLAGS, 32'h180);
    wr(`ACMP_IDX_FLAGS, 32'h100);
    rc(`ACMP_IDX_FLAGS, 32'h80);
    irq(1'b1);
    wr(`ACMP_IDX_FLAGS, 32'h80);
    irq(1'b0);
    wr(`ACMP_IDX_MASKS, 32'h0F0);
    conv_u.send(3'h7, 12'h0);
    irq(1'b1);
    wr(`ACMP_IDX_MASKS, 32'h1F0);
    irq(1'b0);
  endtask
  // Clear of data-ready lands on the same edge as a new result: the set must win
  task s_race;
    fork
      wr(`ACMP_IDX_FLAGS, 32'h100);
      begin
        @(posedge hclk);
        conv_u.send(3'h7, 12'h0);
      end
    join
    rc(`ACMP_IDX_FLAGS, 32'h100);
  endtask
  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    s_reset;
    s_codes;
    s_pol;
    s_bat;
    s_irq;
    s_race;
    conclude;
  end
endmodule // tb_aux_adc_threshold_compare_irq
